//--- logic/power_mode_defs.vh
// Constants for the low-power mode sequencer: register map, fields, states.
`ifndef POWER_MODE_DEFS_VH
`define POWER_MODE_DEFS_VH
// =====================================================================
// Register byte offsets.
`define OFS_CONTROL      12'h000
`define OFS_CLOCK        12'h004
`define OFS_GATE         12'h008
`define OFS_BACKUP       12'h00C
`define OFS_WATCHDOG     12'h010
`define OFS_STATUS       12'h014
// =====================================================================
// Control register fields.
`define BIT_SLEEP_EXIT   0
`define BIT_DEEP_SLEEP   1
`define BIT_EVT_PEND     2
`define BIT_POWER_DOWN_DEEP_SLEEP         3
// Clock register fields.
`define CLK_SRC_LO       0
`define CLK_SRC_HI       1
`define BIT_PLL_EN       2
`define BIT_EXT_OSC_EN   3
`define CLK_DIV_LO       4
`define CLK_DIV_HI       7
// Backup domain control fields.
`define BIT_RTC_RUN      0
`define BIT_SLOW_XTAL    1
// Watchdog start and status fields.
`define BIT_WDG_START    0
`define STAT_MODE_LO     0
`define STAT_MODE_HI     2
`define BIT_STAT_WDG     3
`define BIT_STAT_IGN     4
// =====================================================================
// Reset values and clock source codes.
`define CLK_SRC_INT      2'h0
`define CLK_DIV_RESET    4'h0
`define CTRL_RESET       4'h0
// =====================================================================
// Sequencer states.
`define ST_RUN           3'h0
`define ST_SLEEP         3'h1
`define ST_STOP_WAIT     3'h2
`define ST_STOP          3'h3
`define ST_WAKE_OSC      3'h4
`define ST_STANDBY       3'h5
`endif

//--- logic/low_power_mode_controller.v
// Run, Sleep, Stop and Standby mode sequencer with an APB register slave.
`timescale 1ns/10ps
// =====================================================================
// Operation
// - Reset brings Run mode, clocks running.
// - Low supply holds the block in reset.
// - Sleep stops only the processor clock.
// - Run allows clock slowing and gating.
// - Plain wait with no options enters Sleep.
// - Sleep-on-exit enters Sleep at handler return.
// - Pins keep Run state in Sleep, Stop.
// - Wait-for-interrupt Sleep wakes on accepted interrupt.
// - Wait-for-event Sleep wakes on events, masked pending.
// - Event-mode line wakes without pending bits.
// - Deep sleep without power-down enters Stop.
// - Stop halts domain clocks, PLL, fast oscillators.
// - Pending flags make Stop entry ignored.
// - Stop waits for flash programming to finish.
// - Stop waits for peripheral bus transfer end.
// - Started watchdog runs until reset only.
// - RTC and slow crystal follow backup bits.
// - Stop exits on matching event-line kind.
// - Stop exit selects internal fast oscillator.
// - Deep sleep with power-down selects Standby.
// =====================================================================
`include "power_mode_defs.vh"

module low_power_mode_controller #(
    parameter GATES = 8
) (
    input  wire              clock,
    input  wire              reset,
    input  wire              supply_low,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output wire              pslverr,
    output reg  [31:0]       prdata,
    input  wire              wait_for_interrupt,
    input  wire              wait_for_event,
    input  wire              handler_exit,
    input  wire              irq_accepted,
    input  wire              irq_pending_masked,
    input  wire              event_line_event,
    input  wire              event_line_irq,
    input  wire              event_line_pending_flags,
    input  wire              periph_irq_pending,
    input  wire              rtc_alarm_flag,
    input  wire              flash_busy,
    input  wire              apb_busy,
    input  wire              internal_fast_osc_ready,
    input  wire              watchdog_hw_option,
    output reg               cpu_clock_en,
    output reg  [GATES-1:0]  periph_clock_en,
    output reg               domain_clock_en,
    output reg  [3:0]        sys_clock_div,
    output reg  [1:0]        sys_clock_sel,
    output reg               pll_en,
    output reg               internal_fast_osc_en,
    output reg               external_fast_osc_en,
    output reg               io_hold,
    output reg               standby_req,
    output reg               cpu_resume,
    output reg               watchdog_run,
    output reg               rtc_clock_en,
    output reg               slow_crystal_en,
    output reg               supply_reset_threshold
);

    // =================================================================
    // Input synchronisers for pins from outside the clock domain.
    reg  [1:0] sup_sync_q;
    reg  [1:0] evt_sync_q;
    reg  [1:0] eirq_sync_q;
    wire       sup_low;
    wire       evt_line;
    wire       eirq_line;

    // Two flops each; only the second stage is read.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            sup_sync_q  <= 2'h3;
            evt_sync_q  <= 2'h0;
            eirq_sync_q <= 2'h0;
        end else begin
            sup_sync_q  <= {sup_sync_q[0], supply_low};
            evt_sync_q  <= {evt_sync_q[0], event_line_event};
            eirq_sync_q <= {eirq_sync_q[0], event_line_irq};
        end
    end

    assign sup_low   = sup_sync_q[1];
    assign evt_line  = evt_sync_q[1];
    assign eirq_line = eirq_sync_q[1];

    // =================================================================
    // Software registers.
    reg  [3:0]       ctrl_q;
    reg  [1:0]       clk_src_q;
    reg              pll_en_q;
    reg              ext_osc_q;
    reg  [3:0]       clk_div_q;
    reg  [GATES-1:0] gate_q;
    reg  [1:0]       backup_q;
    reg              wdg_q;
    reg              ignored_q;
    reg              strap_done_q;
    reg  [2:0]       state_q;
    reg  [2:0]       state_d;
    reg              by_event_q;
    reg              by_event_d;
    reg              armed_q;
    reg              armed_d;
    reg              resume_d;
    reg              ignore_d;
    reg              to_int_clk;

    wire setup_phase = psel & ~penable;
    wire wr_access   = psel & penable & pwrite;
    wire rd_setup    = setup_phase & ~pwrite;
    wire any_wait    = wait_for_interrupt | wait_for_event;
    wire pending_any = event_line_pending_flags | periph_irq_pending | rtc_alarm_flag;
    wire sleep_exit  = ctrl_q[`BIT_SLEEP_EXIT];
    wire deep_sleep  = ctrl_q[`BIT_DEEP_SLEEP];
    wire evt_pend    = ctrl_q[`BIT_EVT_PEND];
    wire power_down_deep_sleep        = ctrl_q[`BIT_POWER_DOWN_DEEP_SLEEP];

    // Address decode used only for the error response of reads and writes.
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `OFS_CONTROL) || (a == `OFS_CLOCK) || (a == `OFS_GATE)
                  || (a == `OFS_BACKUP) || (a == `OFS_WATCHDOG) || (a == `OFS_STATUS);
        end
    endfunction

    // Zero-wait slave; unmapped addresses answer with an error.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);

    // =================================================================
    // Register writes. Hardware clock-source reload and the ignored
    // flag take precedence over a simultaneous software write.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_q       <= `CTRL_RESET;
            clk_src_q    <= `CLK_SRC_INT;
            pll_en_q     <= 1'b0;
            ext_osc_q    <= 1'b0;
            clk_div_q    <= `CLK_DIV_RESET;
            gate_q       <= {GATES{1'b1}};
            backup_q     <= 2'h0;
            wdg_q        <= 1'b0;
            ignored_q    <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (sup_low) begin
            ctrl_q       <= `CTRL_RESET;
            clk_src_q    <= `CLK_SRC_INT;
            pll_en_q     <= 1'b0;
            ext_osc_q    <= 1'b0;
            clk_div_q    <= `CLK_DIV_RESET;
            gate_q       <= {GATES{1'b1}};
            backup_q     <= 2'h0;
            wdg_q        <= 1'b0;
            ignored_q    <= 1'b0;
            strap_done_q <= 1'b0;
        end else begin
            // The strap is caught once, on the first edge after release.
            strap_done_q <= 1'b1;
            if (!strap_done_q && watchdog_hw_option) begin
                wdg_q <= 1'b1;
            end
            if (wr_access) begin
                if (paddr == `OFS_CONTROL) begin
                    ctrl_q <= pwdata[`BIT_POWER_DOWN_DEEP_SLEEP:`BIT_SLEEP_EXIT];
                end else if (paddr == `OFS_CLOCK) begin
                    clk_src_q <= pwdata[`CLK_SRC_HI:`CLK_SRC_LO];
                    pll_en_q  <= pwdata[`BIT_PLL_EN];
                    ext_osc_q <= pwdata[`BIT_EXT_OSC_EN];
                    clk_div_q <= pwdata[`CLK_DIV_HI:`CLK_DIV_LO];
                end else if (paddr == `OFS_GATE) begin
                    gate_q <= pwdata[GATES-1:0];
                end else if (paddr == `OFS_BACKUP) begin
                    backup_q <= pwdata[`BIT_SLOW_XTAL:`BIT_RTC_RUN];
                end else if (paddr == `OFS_WATCHDOG) begin
                    if (pwdata[`BIT_WDG_START]) begin
                        wdg_q <= 1'b1;
                    end
                end else if (paddr == `OFS_STATUS) begin
                    if (pwdata[`BIT_STAT_IGN]) begin
                        ignored_q <= 1'b0;
                    end
                end
            end
            if (ignore_d) begin
                ignored_q <= 1'b1;
            end
            // Stop exit must land on the internal oscillator.
            if (to_int_clk) begin
                clk_src_q <= `CLK_SRC_INT;
                pll_en_q  <= 1'b0;
                ext_osc_q <= 1'b0;
            end
        end
    end

    // =================================================================
    // Read data is captured in the setup cycle so it stands registered
    // throughout the access cycle.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= 32'h00000000;
            if (paddr == `OFS_CONTROL) begin
                prdata[`BIT_POWER_DOWN_DEEP_SLEEP:`BIT_SLEEP_EXIT] <= ctrl_q;
            end else if (paddr == `OFS_CLOCK) begin
                prdata[`CLK_SRC_HI:`CLK_SRC_LO] <= clk_src_q;
                prdata[`BIT_PLL_EN]             <= pll_en_q;
                prdata[`BIT_EXT_OSC_EN]         <= ext_osc_q;
                prdata[`CLK_DIV_HI:`CLK_DIV_LO] <= clk_div_q;
            end else if (paddr == `OFS_GATE) begin
                prdata[GATES-1:0] <= gate_q;
            end else if (paddr == `OFS_BACKUP) begin
                prdata[`BIT_SLOW_XTAL:`BIT_RTC_RUN] <= backup_q;
            end else if (paddr == `OFS_WATCHDOG) begin
                prdata[`BIT_WDG_START] <= wdg_q;
            end else if (paddr == `OFS_STATUS) begin
                prdata[`STAT_MODE_HI:`STAT_MODE_LO] <= state_q;
                prdata[`BIT_STAT_WDG]               <= wdg_q;
                prdata[`BIT_STAT_IGN]               <= ignored_q;
            end
        end
    end

    // =================================================================
    // Mode sequencer next-state logic.
    always @* begin
        state_d    = state_q;
        by_event_d = by_event_q;
        armed_d    = armed_q;
        resume_d   = 1'b0;
        ignore_d   = 1'b0;
        to_int_clk = 1'b0;
        case (state_q)
            `ST_RUN: begin
                if (any_wait && deep_sleep && power_down_deep_sleep) begin
                    state_d = `ST_STANDBY;
                end else if (any_wait && deep_sleep) begin
                    by_event_d = wait_for_event & ~wait_for_interrupt;
                    if (pending_any) begin
                        ignore_d = 1'b1;
                    end else begin
                        state_d = `ST_STOP_WAIT;
                    end
                end else if (any_wait && !sleep_exit) begin
                    by_event_d = wait_for_event & ~wait_for_interrupt;
                    state_d    = `ST_SLEEP;
                end else if (wait_for_interrupt && sleep_exit) begin
                    armed_d = 1'b1;
                end else if (armed_q && handler_exit && !deep_sleep) begin
                    armed_d    = 1'b0;
                    by_event_d = 1'b0;
                    state_d    = `ST_SLEEP;
                end
            end
            `ST_SLEEP: begin
                // Wake is taken combinationally, so no latency is added.
                if (!by_event_q && irq_accepted) begin
                    state_d  = `ST_RUN;
                    resume_d = 1'b1;
                end else if (by_event_q
                             && (evt_line || (evt_pend && irq_pending_masked))) begin
                    state_d  = `ST_RUN;
                    resume_d = 1'b1;
                end
            end
            `ST_STOP_WAIT: begin
                // Flags are checked every cycle of the wait, not only once.
                if (pending_any) begin
                    state_d  = `ST_RUN;
                    ignore_d = 1'b1;
                    resume_d = 1'b1;
                end else if (!flash_busy && !apb_busy) begin
                    state_d = `ST_STOP;
                end
            end
            `ST_STOP: begin
                if ((!by_event_q && eirq_line) || (by_event_q && evt_line)) begin
                    state_d    = `ST_WAKE_OSC;
                    to_int_clk = 1'b1;
                end
            end
            `ST_WAKE_OSC: begin
                // Latency is the oscillator start-up time.
                if (internal_fast_osc_ready) begin
                    state_d  = `ST_RUN;
                    resume_d = 1'b1;
                end
            end
            `ST_STANDBY: begin
                state_d = `ST_STANDBY;
            end
            default: begin
                state_d = `ST_RUN;
            end
        endcase
    end

    // Sequencer state; the low-supply hold returns it to Run like reset.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q    <= `ST_RUN;
            by_event_q <= 1'b0;
            armed_q    <= 1'b0;
            cpu_resume <= 1'b0;
        end else if (sup_low) begin
            state_q    <= `ST_RUN;
            by_event_q <= 1'b0;
            armed_q    <= 1'b0;
            cpu_resume <= 1'b0;
        end else begin
            state_q    <= state_d;
            by_event_q <= by_event_d;
            armed_q    <= armed_d;
            cpu_resume <= resume_d;
        end
    end

    // =================================================================
    // Clock, oscillator and pin-hold outputs, registered from state.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            cpu_clock_en           <= 1'b1;
            periph_clock_en        <= {GATES{1'b1}};
            domain_clock_en        <= 1'b1;
            sys_clock_div          <= `CLK_DIV_RESET;
            sys_clock_sel          <= `CLK_SRC_INT;
            pll_en                 <= 1'b0;
            internal_fast_osc_en   <= 1'b1;
            external_fast_osc_en   <= 1'b0;
            io_hold                <= 1'b0;
            standby_req            <= 1'b0;
            watchdog_run           <= 1'b0;
            rtc_clock_en           <= 1'b0;
            slow_crystal_en        <= 1'b0;
            supply_reset_threshold <= 1'b1;
        end else begin
            supply_reset_threshold <= sup_low;
            watchdog_run           <= wdg_q;
            rtc_clock_en           <= backup_q[`BIT_RTC_RUN];
            slow_crystal_en        <= backup_q[`BIT_SLOW_XTAL];
            sys_clock_div          <= clk_div_q;
            sys_clock_sel          <= to_int_clk ? `CLK_SRC_INT : clk_src_q;
            standby_req            <= (state_d == `ST_STANDBY);
            // Pins are frozen in their Run state in Sleep and Stop only.
            io_hold <= (state_d == `ST_SLEEP) || (state_d == `ST_STOP);
            if (state_d == `ST_STOP || state_d == `ST_STANDBY) begin
                cpu_clock_en         <= 1'b0;
                periph_clock_en      <= {GATES{1'b0}};
                domain_clock_en      <= 1'b0;
                pll_en               <= 1'b0;
                internal_fast_osc_en <= 1'b0;
                external_fast_osc_en <= 1'b0;
            end else if (state_d == `ST_WAKE_OSC) begin
                cpu_clock_en         <= 1'b0;
                periph_clock_en      <= {GATES{1'b0}};
                domain_clock_en      <= 1'b0;
                pll_en               <= 1'b0;
                internal_fast_osc_en <= 1'b1;
                external_fast_osc_en <= 1'b0;
            end else begin
                // Sleep drops only the processor clock.
                cpu_clock_en         <= (state_d != `ST_SLEEP);
                periph_clock_en      <= gate_q;
                domain_clock_en      <= 1'b1;
                pll_en               <= pll_en_q & ~to_int_clk;
                internal_fast_osc_en <= 1'b1;
                external_fast_osc_en <= ext_osc_q & ~to_int_clk;
            end
        end
    end

endmodule

//--- testbench/power_mode_sva.sv
// Assertion checker for the low-power mode sequencer ports.
`timescale 1ns/10ps
`include "power_mode_defs.vh"
// =====================================================================
// Checker
module power_mode_sva (
    input wire       clock,
    input wire       reset,
    input wire       supply_low,
    input wire       flash_busy,
    input wire       apb_busy,
    input wire       cpu_clock_en,
    input wire       domain_clock_en,
    input wire [1:0] sys_clock_sel,
    input wire       pll_en,
    input wire       internal_fast_osc_en,
    input wire       external_fast_osc_en,
    input wire       io_hold,
    input wire       standby_req,
    input wire       cpu_resume,
    input wire       watchdog_run
);
    reg  [3:0] low_hist_q;
    wire       calm;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Recent supply history, because a low supply may clear the sticky outputs.
    always @(posedge clock or posedge reset) begin
        if (reset)
            low_hist_q <= 4'hF;
        else
            low_hist_q <= {low_hist_q[2:0], supply_low};
    end
    assign calm = (low_hist_q == 4'h0) && !supply_low;
    // =====================================================================
    // Properties
    stop_clocks_a: assert property (!domain_clock_en && !internal_fast_osc_en
        && !standby_req |-> !pll_en && !external_fast_osc_en && !cpu_clock_en && io_hold)
        else $error("stop clocks wrong");
    osc_wake_a: assert property ($rose(internal_fast_osc_en)
        |-> sys_clock_sel == `CLK_SRC_INT && !pll_en) else $error("wake source wrong");
    resume_clock_a: assert property (cpu_resume
        |-> cpu_clock_en && domain_clock_en && !io_hold) else $error("resume with clock off");
    pin_hold_a: assert property (io_hold |-> !cpu_clock_en)
        else $error("pins held in run");
    stop_gate_a: assert property ($fell(domain_clock_en) && !standby_req
        |-> !$past(flash_busy) && !$past(apb_busy)) else $error("stop during access");
    watchdog_stick_a: assert property (watchdog_run && calm |=> watchdog_run)
        else $error("watchdog stopped");
    standby_stay_a: assert property (standby_req && calm |=> standby_req)
        else $error("standby left");
    supply_hold_a: assert property (&low_hist_q
        |-> cpu_clock_en && !io_hold && !standby_req && !watchdog_run)
        else $error("low supply not held");
endmodule

bind low_power_mode_controller power_mode_sva chk (.*);

//--- testbench/core_model.sv
// Behavioural processor core that issues wait and handler-return pulses.
`timescale 1ns/10ps
// =====================================================================
// Core model
module core_model (
    input  wire  clock,
    output logic wait_for_interrupt,
    output logic wait_for_event,
    output logic handler_exit
);
    initial begin
        wait_for_interrupt = 1'b0;
        wait_for_event = 1'b0;
        handler_exit = 1'b0;
    end
    // Each pulse lasts one cycle so the sequencer can take it only once.
    task automatic issue(input int kind);
        @(posedge clock);
        if (kind == 0)
            wait_for_interrupt <= 1'b1;
        else if (kind == 1)
            wait_for_event <= 1'b1;
        else
            handler_exit <= 1'b1;
        @(posedge clock);
        wait_for_interrupt <= 1'b0;
        wait_for_event <= 1'b0;
        handler_exit <= 1'b0;
    endtask
endmodule

//--- testbench/low_power_mode_controller_bench.sv
// Self-checking bench for the low-power mode sequencer.
`timescale 1ns/10ps
`include "power_mode_defs.vh"
module low_power_mode_controller_bench;
    logic        clock, reset, supply_low, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [2:0]  pend;
    logic        irq_accepted, irq_pending_masked, event_line_event, event_line_irq;
    logic        flash_busy, apb_busy, internal_fast_osc_ready, handler_exit, watchdog_hw_option;
    wire         pready, pslverr, wait_for_interrupt, wait_for_event, cpu_clock_en;
    wire         domain_clock_en, pll_en, internal_fast_osc_en, external_fast_osc_en;
    wire         io_hold, standby_req, cpu_resume, watchdog_run, rtc_clock_en;
    wire         slow_crystal_en, supply_reset_threshold;
    wire [31:0]  prdata;
    wire [7:0]   periph_clock_en;
    wire [3:0]   sys_clock_div;
    wire [1:0]   sys_clock_sel;
    int          n_errors, total_checks;
    // =====================================================================
    // Design and core
    low_power_mode_controller #(.GATES(8)) dut (.*,
        .event_line_pending_flags(pend[0]), .periph_irq_pending(pend[1]),
        .rtc_alarm_flag(pend[2]));
    core_model core (.clock(clock), .wait_for_interrupt(wait_for_interrupt),
        .wait_for_event(wait_for_event), .handler_exit(handler_exit));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // =====================================================================
    // Shared tasks
    task automatic end_of_test();
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
    endtask
    function automatic logic hit(input int k);
        case (k)
            0: return cpu_resume === 1'b1;
            1: return domain_clock_en === 1'b0;
            default: return internal_fast_osc_en === 1'b1;
        endcase
    endfunction
    // Bounded wait: 0 resume pulse, 1 domain clocks off, 2 oscillator on.
    task automatic wait_on(input int k);
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge clock) #1;
            if (hit(k)) break;
        end
        check("wait", 1, hit(k));
        if (!hit(k)) end_of_test();
    endtask
    // =====================================================================
    // Scenarios
    task automatic sleep_case(input logic [31:0] ctrl);
        apb(1, `OFS_CONTROL, ctrl);
        core.issue(0);
        if (ctrl[0]) #1 check("armed run", 1, cpu_clock_en);
        if (ctrl[0]) core.issue(2);
        #1 check("cpu clock", 0, cpu_clock_en);
        check("pins", 1, io_hold);
        check("periph", 32'hFF, periph_clock_en);
        check("domain", 1, domain_clock_en);
        @(posedge clock);
        irq_accepted <= 1'b1;
        wait_on(0);
        check("clock back", 1, cpu_clock_en);
        @(posedge clock);
        irq_accepted <= 1'b0;
    endtask
    task automatic wfe_case();
        int k;
        apb(1, `OFS_CONTROL, 32'h4);
        for (k = 0; k < 2; k++) begin
            core.issue(1);
            @(posedge clock);
            irq_pending_masked <= (k == 0);
            event_line_event <= (k == 1);
            wait_on(0);
            @(posedge clock);
            irq_pending_masked <= 1'b0;
            event_line_event <= 1'b0;
        end
    endtask
    task automatic stop_ignored_case();
        int k;
        apb(1, `OFS_CONTROL, 32'h2);
        for (k = 0; k < 3; k++) begin
            @(posedge clock);
            pend <= 3'h1 << k;
            core.issue(k % 2);
            repeat (3) @(posedge clock);
            #1 check("stop refused", 1, domain_clock_en);
            check("cpu kept", 1, cpu_clock_en);
        end
        apb(0, `OFS_STATUS, 32'h0);
        check("ignored flag", 1, rd[`BIT_STAT_IGN]);
        pend <= 3'h0;
    endtask
    task automatic stop_case();
        apb(1, `OFS_CLOCK, 32'h5D);
        @(posedge clock) #1 check("divider", 4'h5, sys_clock_div);
        @(posedge clock);
        flash_busy <= 1'b1;
        internal_fast_osc_ready <= 1'b0;
        core.issue(0);
        repeat (5) @(posedge clock);
        #1 check("stop delayed", 1, domain_clock_en);
        @(posedge clock);
        flash_busy <= 1'b0;
        wait_on(1);
        check("pll", 0, pll_en);
        check("ext osc", 0, external_fast_osc_en);
        check("pins", 1, io_hold);
        @(posedge clock);
        event_line_irq <= 1'b1;
        wait_on(2);
        check("source", `CLK_SRC_INT, sys_clock_sel);
        @(posedge clock);
        event_line_irq <= 1'b0;
        internal_fast_osc_ready <= 1'b1;
        wait_on(0);
    endtask
    task automatic abort_case();
        @(posedge clock);
        apb_busy <= 1'b1;
        core.issue(1);
        repeat (3) @(posedge clock);
        #1 check("bus delay", 1, domain_clock_en);
        @(posedge clock);
        pend <= 3'h2;
        wait_on(0);
        check("no stop", 1, domain_clock_en);
        @(posedge clock);
        pend <= 3'h0;
        apb_busy <= 1'b0;
    endtask
    task automatic reg_case();
        apb(1, `OFS_GATE, 32'h0F);
        @(posedge clock) #1 check("gates", 8'h0F, periph_clock_en);
        apb(1, `OFS_BACKUP, 32'h3);
        @(posedge clock) #1 check("rtc", 2'h3, {rtc_clock_en, slow_crystal_en});
        apb(1, `OFS_WATCHDOG, 32'h1);
        apb(0, 12'h040, 32'h0);
        check("unmapped", 1, err);
        apb(1, `OFS_CONTROL, 32'hA);
        core.issue(1);
        #1 check("standby", 1, standby_req);
        check("watchdog", 1, watchdog_run);
        @(posedge clock);
        supply_low <= 1'b1;
        repeat (5) @(posedge clock);
        #1 check("held", 3'h4, {supply_reset_threshold, standby_req, watchdog_run});
        @(posedge clock);
        supply_low <= 1'b0;
        watchdog_hw_option <= 1'b1;
        repeat (5) @(posedge clock);
        #1 check("strap", 1, watchdog_run);
    endtask
    // =====================================================================
    // Main sequence
    initial begin
        {reset, pend} = 4'h8;
        {supply_low, psel, penable, pwrite, paddr, pwdata} = 0;
        {irq_accepted, irq_pending_masked, event_line_event, event_line_irq} = 4'h0;
        {watchdog_hw_option, flash_busy, apb_busy, internal_fast_osc_ready} = 4'h1;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        repeat (3) @(posedge clock);
        apb(0, `OFS_GATE, 32'h0);
        check("gate reset", 32'hFF, rd);
        check("source reset", `CLK_SRC_INT, sys_clock_sel);
        sleep_case(32'h0);
        sleep_case(32'h1);
        wfe_case();
        stop_ignored_case();
        stop_case();
        abort_case();
        reg_case();
        end_of_test();
    end
endmodule
